// ---- hdl/pibm_mapper.sv ----
// Process image byte mapper: places channel words and status bytes into
// the coupler's input image and picks control bytes out of its output image.
// Assumes all inputs are synchronous to clk and the master writes control
// bytes at the positions flagged in outUsed.
//
// Functional notes
// R1: Plain little-endian: channel n at word n.
// R2: Big-endian swaps the two data bytes.
// R3: Low byte is bits 7:0, high 15:8.
// R4: Complete evaluation adds one control/status byte.
// R5: Status byte sits at channel's control slot.
// R6: Master writes control byte at same position.
// R7: Packed layout places bytes contiguously, three per channel.
// R8: Aligned layout: control word, then data word.
// R9: Reserved bytes carry no channel information.
// R10: Bytes beyond configured channels stay untouched.
// R11: Output image used only with complete evaluation.
// R12: Settings take defaults until tool changes them.
// R13: Fieldbus reads win over configuration port reads.
// R14: Reserved bytes read back as zero.
`timescale 1ns/1ps
module pibm_mapper #(
   parameter int NUM_CH = 2
) (
   input  wire logic                         clk,
   input  wire logic                         srst,
   input  wire logic [NUM_CH-1:0][15:0]      chValue,
   input  wire logic [NUM_CH-1:0][7:0]       chStatus,
   input  wire logic [4*NUM_CH-1:0][7:0]     outImage,
   input  wire logic                         cfgWrEn,
   input  wire logic                         cfgWrCompleteEval,
   input  wire logic                         cfgWrBigEndian,
   input  wire logic                         cfgWrWordAlign,
   input  wire logic                         fbRdReq,
   input  wire logic [$clog2(4*NUM_CH)-1:0]  fbRdAddr,
   input  wire logic                         cfgRdReq,
   input  wire logic [$clog2(4*NUM_CH)-1:0]  cfgRdAddr,
   output logic      [4*NUM_CH-1:0][7:0]     inImage,
   output logic      [4*NUM_CH-1:0]          inUsed,
   output logic      [4*NUM_CH-1:0]          outUsed,
   output logic      [NUM_CH-1:0][7:0]       ctrlByte,
   output logic                              completeEval,
   output logic                              bigEndian,
   output logic                              wordAlign,
   output logic      [7:0]                   fbRdData,
   output logic                              fbRdValid,
   output logic      [7:0]                   cfgRdData,
   output logic                              cfgRdValid,
   output logic                              cfgRdStall
);
   localparam int IMG_BYTES = 4 * NUM_CH;

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   // Only the one- and two-channel layouts are defined.
   if (NUM_CH < 1 || NUM_CH > pibm_pkg::MAX_CH) begin : g_bad_ch
      $error("pibm_mapper: NUM_CH must be 1 or 2");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                         completeEval;
      logic                         bigEndian;
      logic                         wordAlign;
      logic [IMG_BYTES-1:0][7:0]    inImage;
      logic [IMG_BYTES-1:0]         inUsed;
      logic [IMG_BYTES-1:0]         outUsed;
      logic [NUM_CH-1:0][7:0]       ctrlByte;
      logic [7:0]                   fbRdData;
      logic                         fbRdValid;
      logic [7:0]                   cfgRdData;
      logic                         cfgRdValid;
      logic                         cfgRdStall;
   } pibm_state_t;

   pibm_state_t state_q;
   pibm_state_t state_d;

   // Next state: settings, image layout, control byte pick-up and reads.
   // The image is rebuilt every cycle, so a settings change shows in the
   // next image without any stale bytes left behind.
   always_comb begin
      int base;
      int dataPos;
      int stride;
      logic [7:0] firstByte;
      logic [7:0] secondByte;
      base = 0;
      dataPos = 0;
      stride = 0;
      firstByte = 8'h00;
      secondByte = 8'h00;
      state_d = state_q;
      // Outside reset, settings change only on a configuration write.
      if (cfgWrEn) begin // R12
         state_d.completeEval = cfgWrCompleteEval;
         state_d.bigEndian    = cfgWrBigEndian;
         state_d.wordAlign    = cfgWrWordAlign;
      end
      // Unoccupied bytes default to zero and unused; reserved bytes are zero but marked used.
      state_d.inImage = '0; // R14
      state_d.inUsed  = '0; // R10
      state_d.outUsed = '0; // R11
      state_d.ctrlByte = '0;
      if (!state_q.completeEval) begin
         stride  = pibm_pkg::STRIDE_PLAIN;
         dataPos = pibm_pkg::POS_DATA_PLAIN;
      end else if (state_q.wordAlign) begin
         stride  = pibm_pkg::STRIDE_ALIGNED; // R8
         dataPos = pibm_pkg::POS_DATA_ALIGNED;
      end else begin
         stride  = pibm_pkg::STRIDE_PACKED; // R7
         dataPos = pibm_pkg::POS_DATA_PACKED;
      end
      for (int n = 0; n < NUM_CH; n++) begin
         base = n * stride; // R1
         // Little-endian puts the low byte first, big-endian the high one.
         if (state_q.bigEndian) begin // R2
            firstByte  = chValue[n][15:8];
            secondByte = chValue[n][7:0];
         end else begin
            firstByte  = chValue[n][7:0]; // R3
            secondByte = chValue[n][15:8];
         end
         state_d.inImage[base+dataPos]   = firstByte;
         state_d.inImage[base+dataPos+1] = secondByte;
         state_d.inUsed[base+dataPos]    = 1'b1;
         state_d.inUsed[base+dataPos+1]  = 1'b1;
         if (state_q.completeEval) begin // R4
            state_d.inImage[base+pibm_pkg::POS_CTRL] = chStatus[n]; // R5
            state_d.inUsed[base+pibm_pkg::POS_CTRL]  = 1'b1;
            state_d.outUsed[base+pibm_pkg::POS_CTRL] = 1'b1; // R11
            state_d.ctrlByte[n] = outImage[base+pibm_pkg::POS_CTRL]; // R6
            if (state_q.wordAlign) begin
               // Reserved space is occupied but never carries data.
               state_d.inImage[base+pibm_pkg::POS_RESERVED] = pibm_pkg::RESERVED_FILL; // R9
               state_d.inUsed[base+pibm_pkg::POS_RESERVED]  = 1'b1;
            end
         end
      end
      // One read port into the image; the fieldbus always takes it first.
      // A configuration read must hold its request while stalled.
      state_d.fbRdValid  = fbRdReq;
      state_d.fbRdData   = fbRdReq ? state_q.inImage[fbRdAddr] : 8'h00;
      state_d.cfgRdValid = cfgRdReq && !fbRdReq; // R13
      state_d.cfgRdStall = cfgRdReq && fbRdReq;
      state_d.cfgRdData  = (cfgRdReq && !fbRdReq) ? state_q.inImage[cfgRdAddr] : 8'h00;
   end

   // State register; reset restores the default mapping settings.
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= '0;
         state_q.completeEval <= pibm_pkg::RST_COMPLETE_EVAL; // R12
         state_q.bigEndian    <= pibm_pkg::RST_BIG_ENDIAN;
         state_q.wordAlign    <= pibm_pkg::RST_WORD_ALIGN;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Every output is a field of the state register.
   assign inImage      = state_q.inImage;
   assign inUsed       = state_q.inUsed;
   assign outUsed      = state_q.outUsed;
   assign ctrlByte     = state_q.ctrlByte;
   assign completeEval = state_q.completeEval;
   assign bigEndian    = state_q.bigEndian;
   assign wordAlign    = state_q.wordAlign;
   assign fbRdData     = state_q.fbRdData;
   assign fbRdValid    = state_q.fbRdValid;
   assign cfgRdData    = state_q.cfgRdData;
   assign cfgRdValid   = state_q.cfgRdValid;
   assign cfgRdStall   = state_q.cfgRdStall;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Image checks look one cycle back at settings and inputs.
   property p_plain_little;
      @(posedge clk) disable iff (srst)
         $past(!state_q.completeEval && !state_q.bigEndian) && !$past(srst)
         |-> inImage[0] == $past(chValue[0][7:0]) && inImage[1] == $past(chValue[0][15:8]);
   endproperty
   a_plain_little: assert property (p_plain_little) else $error("plain layout wrong"); // R1

   property p_big_swap;
      @(posedge clk) disable iff (srst)
         $past(!state_q.completeEval && state_q.bigEndian) && !$past(srst)
         |-> inImage[0] == $past(chValue[0][15:8]) && inImage[1] == $past(chValue[0][7:0]);
   endproperty
   a_big_swap: assert property (p_big_swap) else $error("big-endian swap wrong"); // R2

   property p_aligned_bytes;
      @(posedge clk) disable iff (srst)
         $past(state_q.completeEval && state_q.wordAlign && !state_q.bigEndian) && !$past(srst)
         |-> inImage[2] == $past(chValue[0][7:0]) && inImage[3] == $past(chValue[0][15:8]);
   endproperty
   a_aligned_bytes: assert property (p_aligned_bytes) else $error("aligned data wrong"); // R3

   property p_status_slot;
      @(posedge clk) disable iff (srst)
         $past(state_q.completeEval) && !$past(srst) |-> inImage[0] == $past(chStatus[0]) && inUsed[0];
   endproperty
   a_status_slot: assert property (p_status_slot) else $error("status byte missing"); // R5

   property p_packed;
      @(posedge clk) disable iff (srst)
         $past(state_q.completeEval && !state_q.wordAlign && state_q.bigEndian) && !$past(srst)
         |-> inImage[1] == $past(chValue[0][15:8]) && inImage[2] == $past(chValue[0][7:0]);
   endproperty
   a_packed: assert property (p_packed) else $error("packed layout wrong"); // R7

   property p_reserved_zero;
      @(posedge clk) disable iff (srst)
         $past(state_q.completeEval && state_q.wordAlign) && !$past(srst) |-> inImage[1] == 8'h00 && inUsed[1];
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved byte not zero"); // R9

   property p_used_count;
      @(posedge clk) disable iff (srst)
         !$past(srst) |-> $countones(inUsed) == NUM_CH * (!$past(state_q.completeEval) ? 2 :
                                                         ($past(state_q.wordAlign) ? 4 : 3));
   endproperty
   a_used_count: assert property (p_used_count) else $error("occupied byte count wrong"); // R10

   property p_out_image;
      @(posedge clk) disable iff (srst)
         !$past(srst) |-> ($past(state_q.completeEval) ? outUsed[0] && ctrlByte[0] == $past(outImage[0])
                                                        : outUsed == '0 && ctrlByte == '0);
   endproperty
   a_out_image: assert property (p_out_image) else $error("output image use wrong"); // R11

   property p_defaults;
      @(posedge clk) $past(srst) && !srst |-> completeEval == pibm_pkg::RST_COMPLETE_EVAL &&
         bigEndian == pibm_pkg::RST_BIG_ENDIAN && wordAlign == pibm_pkg::RST_WORD_ALIGN;
   endproperty
   a_defaults: assert property (p_defaults) else $error("settings not default after reset"); // R12

   property p_fb_wins;
      @(posedge clk) disable iff (srst)
         fbRdReq && cfgRdReq |=> fbRdValid && !cfgRdValid && cfgRdStall;
   endproperty
   a_fb_wins: assert property (p_fb_wins) else $error("fieldbus lost arbitration"); // R13

   property p_cfg_served;
      @(posedge clk) disable iff (srst)
         cfgRdReq && !fbRdReq |=> cfgRdValid && cfgRdData == $past(state_q.inImage[cfgRdAddr]);
   endproperty
   a_cfg_served: assert property (p_cfg_served) else $error("config read not served"); // R13

   property p_fb_data;
      @(posedge clk) disable iff (srst)
         fbRdReq |=> fbRdValid && fbRdData == $past(state_q.inImage[fbRdAddr]);
   endproperty
   a_fb_data: assert property (p_fb_data) else $error("fieldbus read data wrong"); // R13

   // Bytes outside the current layout must read zero. A byte left over from the
   // previous layout would trip this right after a settings change.
   for (genvar i = 0; i < IMG_BYTES; i++) begin : g_unused
      property p_unused_zero;
         @(posedge clk) disable iff (srst)
            !inUsed[i] |-> inImage[i] == 8'h00;
      endproperty
      a_unused_zero: assert property (p_unused_zero) else $error("unused byte not zero"); // R10
   end

   // Second channel checks. A one-channel build has no bytes for them, so they
   // are only built when the second slot exists.
   if (NUM_CH > 1) begin : g_second_ch
      property p_second_plain;
         @(posedge clk) disable iff (srst)
            $past(!state_q.completeEval && !state_q.bigEndian) && !$past(srst)
            |-> inImage[2] == $past(chValue[1][7:0]) && inImage[3] == $past(chValue[1][15:8]);
      endproperty
      a_second_plain: assert property (p_second_plain) else $error("channel 1 plain layout wrong"); // R1

      property p_second_packed;
         @(posedge clk) disable iff (srst)
            $past(state_q.completeEval && !state_q.wordAlign) && !$past(srst)
            |-> inImage[3] == $past(chStatus[1]) && outUsed[3] && ctrlByte[1] == $past(outImage[3]);
      endproperty
      a_second_packed: assert property (p_second_packed) else $error("channel 1 control slot wrong"); // R4

      property p_second_aligned;
         @(posedge clk) disable iff (srst)
            $past(state_q.completeEval && state_q.wordAlign && !state_q.bigEndian) && !$past(srst)
            |-> inImage[4] == $past(chStatus[1]) && inImage[5] == pibm_pkg::RESERVED_FILL &&
                inImage[6] == $past(chValue[1][7:0]) && inImage[7] == $past(chValue[1][15:8]);
      endproperty
      a_second_aligned: assert property (p_second_aligned) else $error("channel 1 aligned layout wrong"); // R8
   end

   // Main scenarios that the bench is expected to reach.
   c_aligned: cover property (@(posedge clk) disable iff (srst) completeEval && wordAlign);
   c_packed: cover property (@(posedge clk) disable iff (srst) completeEval && !wordAlign && bigEndian);
   c_stall: cover property (@(posedge clk) disable iff (srst) cfgRdStall ##1 cfgRdValid);
   c_plain_big: cover property (@(posedge clk) disable iff (srst) !completeEval && bigEndian);
endmodule : pibm_mapper

// ---- hdl/pibm_pkg.sv ----
// Package for the process image byte mapper: byte layout constants and
// the mapping settings that apply after reset.
// Assumes the coupler treats byte index 2w as the low byte of word w.
package pibm_pkg;
   // ----------------------------------------------------------------
   // Measurement and byte widths
   // ----------------------------------------------------------------
   localparam int BYTE_W  = 8;
   localparam int VALUE_W = 16;
   localparam int MAX_CH  = 2;
   // ----------------------------------------------------------------
   // Bytes per channel in each layout
   // ----------------------------------------------------------------
   localparam int STRIDE_PLAIN   = 2;
   localparam int STRIDE_PACKED  = 3;
   localparam int STRIDE_ALIGNED = 4;
   // ----------------------------------------------------------------
   // Byte positions inside a channel's slot
   // ----------------------------------------------------------------
   localparam int POS_CTRL          = 0;
   localparam int POS_RESERVED      = 1;
   localparam int POS_DATA_PLAIN    = 0;
   localparam int POS_DATA_PACKED   = 1;
   localparam int POS_DATA_ALIGNED  = 2;
   localparam logic [7:0] RESERVED_FILL = 8'h00;
   // ----------------------------------------------------------------
   // Mapping settings after reset (coupler defaults)
   // ----------------------------------------------------------------
   localparam logic RST_COMPLETE_EVAL = 1'b0;
   localparam logic RST_BIG_ENDIAN    = 1'b0;
   localparam logic RST_WORD_ALIGN    = 1'b0;
endpackage : pibm_pkg

// ---- verification/pibm_coupler_model.sv ----
// Model of the coupler output image as the fieldbus master writes it.
// Assumes outUsed from the mapper marks the control byte slots.
`timescale 1ns/1ps
module pibm_coupler_model (
   input  wire logic            clk,
   input  wire logic [7:0]      outUsed,
   output logic      [7:0][7:0] outImage
);
   logic [7:0] churn = 8'h00;
   // ------------------------------------------------------------
   // Output image
   // ------------------------------------------------------------
   // Control slots carry 8'hc0 plus their index. Other slots change every
   // cycle, so a stale value can never pass for a control byte.
   always @(posedge clk) begin
      churn <= churn + 8'h01;
      for (int i = 0; i < 8; i++) begin
         outImage[i] <= outUsed[i] ? 8'hc0 + 8'(i) : churn ^ 8'(i);
      end
   end
endmodule : pibm_coupler_model

// ---- verification/test_process_image_byte_mapper.sv ----
// Self-checking bench for the byte mapper with two channels.
// Assumes the coupler model drives the output image.
`timescale 1ns/1ps
module test_process_image_byte_mapper;
   logic             clk = 1'b0;
   logic             srst = 1'b1;
   logic [1:0][15:0] chValue = {16'hc3d4, 16'ha1b2};
   logic [1:0][7:0]  chStatus = {8'h6f, 8'h5e};
   logic [7:0][7:0]  outImage, inImage;
   logic [7:0]       inUsed, outUsed, fbRdData, cfgRdData;
   logic [1:0][7:0]  ctrlByte;
   logic [2:0]       wrSet = 3'h0;
   logic [2:0]       fbRdAddr = 3'h0, cfgRdAddr = 3'h0;
   logic             cfgWrEn = 1'b0, fbRdReq = 1'b0, cfgRdReq = 1'b0;
   logic             completeEval, bigEndian, wordAlign, fbRdValid, cfgRdValid, cfgRdStall;
   int               miscompares = 0;
   int               checks = 0;
   // ------------------------------------------------------------
   // Clock, design and partner
   // ------------------------------------------------------------
   initial forever #2.5 clk = ~clk;
   pibm_mapper #(.NUM_CH(2)) i_dut (.clk(clk), .srst(srst), .chValue(chValue), .chStatus(chStatus),
      .outImage(outImage), .cfgWrEn(cfgWrEn), .cfgWrCompleteEval(wrSet[2]), .cfgWrBigEndian(wrSet[1]),
      .cfgWrWordAlign(wrSet[0]), .fbRdReq(fbRdReq), .fbRdAddr(fbRdAddr), .cfgRdReq(cfgRdReq),
      .cfgRdAddr(cfgRdAddr), .inImage(inImage), .inUsed(inUsed), .outUsed(outUsed), .ctrlByte(ctrlByte),
      .completeEval(completeEval), .bigEndian(bigEndian), .wordAlign(wordAlign), .fbRdData(fbRdData),
      .fbRdValid(fbRdValid), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .cfgRdStall(cfgRdStall));
   pibm_coupler_model i_coupler (.clk(clk), .outUsed(outUsed), .outImage(outImage));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic compare(input string name, input logic [63:0] expv, input logic [63:0] got);
      checks++;
      if (got !== expv) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, expv, got);
      end
   endtask : compare
   task automatic report_and_stop();
      if (miscompares == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop
   // Works out the whole image for mode m (bit 2 complete, 1 big, 0 aligned).
   task automatic check_image(input logic [2:0] m);
      logic [7:0][7:0] expImg;
      logic [7:0]      expUsed, expOut, first, second;
      logic [1:0][7:0] expCtrl;
      int              base;
      expImg = '0;
      expUsed = '0;
      expOut = '0;
      expCtrl = '0;
      for (int n = 0; n < 2; n++) begin
         first = m[1] ? chValue[n][15:8] : chValue[n][7:0];
         second = m[1] ? chValue[n][7:0] : chValue[n][15:8];
         base = m[2] ? (m[0] ? 4 * n : 3 * n) : 2 * n;
         if (m[2]) begin
            expImg[base] = chStatus[n];
            expOut[base] = 1'b1;
            expCtrl[n] = 8'hc0 + 8'(base);
            base = base + (m[0] ? 2 : 1);
         end
         expImg[base] = first;
         expImg[base + 1] = second;
         expUsed = expUsed | ((m[2] ? (m[0] ? 8'h0f : 8'h07) : 8'h03) << (m[2] ? (m[0] ? 4 * n : 3 * n) : 2 * n));
      end
      compare("settings", 64'(m), 64'({completeEval, bigEndian, wordAlign}));
      compare("inImage", expImg, inImage);
      compare("inUsed", 64'(expUsed), 64'(inUsed));
      compare("outUsed", 64'(expOut), 64'(outUsed));
      compare("ctrlByte", 64'(expCtrl), 64'(ctrlByte));
   endtask : check_image
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Defaults after reset give the plain little-endian layout.
   task automatic check_reset_defaults();
      check_image(3'h0);
   endtask : check_reset_defaults
   // A fieldbus read and a configuration read in the same cycle; the
   // configuration read must wait and keep its request up.
   task automatic check_read_priority();
      @(posedge clk);
      fbRdReq <= 1'b1;
      fbRdAddr <= 3'h1;
      cfgRdReq <= 1'b1;
      cfgRdAddr <= 3'h2;
      @(posedge clk);
      fbRdReq <= 1'b0;
      #1;
      compare("fbRdValid", 64'h1, 64'(fbRdValid));
      compare("fbRdData", 64'ha1, 64'(fbRdData));
      compare("cfgRdStall", 64'h1, 64'(cfgRdStall));
      compare("cfgRdValid", 64'h0, 64'(cfgRdValid));
      @(posedge clk);
      #1;
      compare("cfgRdValid", 64'h1, 64'(cfgRdValid));
      compare("cfgRdData", 64'hd4, 64'(cfgRdData));
      @(posedge clk);
      cfgRdReq <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : check_read_priority
   // Every setting combination, written through the settings strobe.
   // The first channel's high byte moves with the mode, so a stale image shows.
   task automatic check_layouts();
      for (int m = 7; m >= 0; m--) begin
         @(posedge clk);
         cfgWrEn <= 1'b1;
         wrSet <= 3'(m);
         chValue[0][15:8] <= 8'ha1 ^ 8'(m);
         @(posedge clk);
         cfgWrEn <= 1'b0;
         repeat (4) @(posedge clk);
         #1;
         check_image(3'(m));
      end
   endtask : check_layouts
   // A reset in mid-run after the richest layout must bring back the defaults.
   task automatic check_mid_reset();
      @(posedge clk);
      cfgWrEn <= 1'b1;
      wrSet <= 3'h7;
      @(posedge clk);
      cfgWrEn <= 1'b0;
      repeat (4) @(posedge clk);
      srst <= 1'b1;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check_image(3'h0);
   endtask : check_mid_reset
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check_reset_defaults();
      check_read_priority();
      check_layouts();
      check_mid_reset();
      report_and_stop();
   end
   initial begin
      #20000;
      miscompares++;
      report_and_stop();
   end
endmodule : test_process_image_byte_mapper
